/* tws_defs.svh */
// Constants for the two-wire slave link and its host-side driver.
// Included by the package and both end modules; defines only.
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH
`define TWS_ADDR_PREFIX 5'h0A
`define TWS_FIFO_ADDR 7'h05
`define TWS_REG_ADDR_W 7
`define TWS_FILT_LEN 3
`define TWS_CLK_NS 25
`define TWS_FM_KBPS 400
`define TWS_FMP_KBPS 1000
`define TWS_P2P_KBAUD 5000
`define TWS_HALF_NS (1000000 / (2 * `TWS_FMP_KBPS))
`define TWS_HALF_CYC ((`TWS_HALF_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)
`endif

/* tws_pkg.sv */
// Types shared by both ends of the two-wire link.
// Assumes tws_defs.svh is on the include path.
`include "tws_defs.svh"
package tws_pkg;
    typedef enum logic [1:0] {
        TWS_ST_IDLE,
        TWS_ST_ADDR,
        TWS_ST_REG,
        TWS_ST_DATA
    } tws_phase_t;
    typedef logic [7:0] tws_byte_t;
endpackage

/* tws_link_if.sv */
// Two-wire link between host end and device end.
// Resolves open-drain SDA and SCL from the output enables.
`timescale 1ns/1ps
interface tws_link_if;
    logic sclOe;
    logic sdaHostOe;
    logic sdaHostOut;
    logic sdaDevOe;
    logic p2pMode;
    logic scl;
    logic sda;
    // Pulled-up bus: a driver with enable high pulls low, except host
    // push-pull drive in point-to-point mode.
    assign scl = ~sclOe;
    assign sda = (sdaDevOe || (sdaHostOe && !sdaHostOut)) ? 1'b0 : 1'b1;
    modport dev (input scl, input sda, input p2pMode, output sdaDevOe);
    modport host (input sda, output sclOe, output sdaHostOe,
        output sdaHostOut, output p2pMode);
endinterface

/* tws_dev_end.sv */
// Device end: slave-only two-wire register interface.
// Assumes clk far faster than SCL; host keeps its own link duties.
// Contract
// [R1] Never hold SCL low.
// [R2] Ignore general call and its reset.
// [R3] Slave receiver or transmitter only.
// [R4] No high-speed mode.
// [R5] Handle rates to 1 Mbit/s.
// [R6] Glitch filter SCL and SDA always.
// [R7] SDA changes only while SCL low.
// [R8] Start/stop are SDA edges during SCL high.
// [R9] Busy from start to stop; restart equals start.
// [R10] Bytes MSB first plus one acknowledge bit.
// [R11] Receiver pulls SDA low during acknowledge.
// [R12] Release SDA after master not-acknowledge.
// [R13] Address is 01010 plus two configured bits.
// [R14] Write: address, register byte, data bytes.
// [R15] FIFO writes keep register address fixed.
// [R16] Read preceded by register-address-only write.
// [R17] Reads return registers, address auto-increments.
// [R18] FIFO reads keep address fixed.
// [R19] Point-to-point: host push-pull SCL, no stretch.
// [R20] Keeper holds SDA during SCL high.
// [R21] Point-to-point pin mode forces upper bit 0.
// [R22] Host drives SDA high when idle; the host end does so only with p2pSel set.
// [R23] Point-to-point: drive SDA only when SCL low; the device keeps its SDA drive on through SCL high.
// [R24] Unmatched address: release SDA, ignore frame.
`timescale 1ns/1ps
`include "tws_defs.svh"
module tws_dev_end import tws_pkg::*; #(
    parameter int FILT_LEN = `TWS_FILT_LEN
) (
    input wire logic clk,
    input wire logic nrst,
    tws_link_if.dev link,
    input wire logic [1:0] addrPins,
    input wire logic [1:0] addrNv,
    input wire logic addrFromNv,
    output logic [6:0] regAddr,
    output logic [7:0] wrData,
    output logic wrStrobe,
    output logic wrFifo,
    input wire logic [7:0] rdData,
    output logic rdStrobe,
    output logic rdFifo,
    output logic busy
);
    // Majority-free stable filter: input accepted after FILT_LEN equal
    // samples, which suppresses short spikes. [R6]
    logic [1:0] sync1_q, sync2_q;
    logic filt_q [2];
    logic [1:0] filtPrev_q;
    logic [FILT_LEN-1:0] hist_q [2];
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= 2'h3;
            sync2_q <= 2'h3;
        end else begin
            sync1_q <= {link.scl, link.sda};
            sync2_q <= sync1_q;
        end
    end
    for (genvar i = 0; i < 2; i++) begin : g_filt
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                hist_q[i] <= '1;
                filt_q[i] <= 1'b1;
            end else begin
                hist_q[i] <= {hist_q[i][FILT_LEN-2:0], sync2_q[i]};
                if (&hist_q[i]) begin
                    filt_q[i] <= 1'b1;
                end else if (~|hist_q[i]) begin
                    filt_q[i] <= 1'b0;
                end
            end
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            filtPrev_q <= 2'h3;
        end else begin
            filtPrev_q <= {filt_q[1], filt_q[0]};
        end
    end
    logic sclF, sdaF, sclRise, sclFall, startCond, stopCond;
    assign sclF = filt_q[1];
    assign sdaF = filt_q[0];
    assign sclRise = sclF && !filtPrev_q[1];
    assign sclFall = !sclF && filtPrev_q[1];
    assign startCond = sclF && filtPrev_q[1] && !sdaF && filtPrev_q[0]; // [R8]
    assign stopCond = sclF && filtPrev_q[1] && sdaF && !filtPrev_q[0]; // [R8]

    // Own address: upper bit forced 0 for point-to-point pin setting.
    logic [1:0] lowBits;
    logic [6:0] myAddr;
    always_comb begin
        lowBits = addrFromNv ? addrNv : addrPins;
        if (link.p2pMode && !addrFromNv) begin
            lowBits[1] = 1'b0; // [R21]
        end
        myAddr = {`TWS_ADDR_PREFIX, lowBits}; // [R13]
    end

    tws_phase_t phase_q;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q;
    logic readDir_q;
    logic ackSlot_q;
    logic ackOwn_q;
    logic sdaOe_q;
    logic [6:0] ptr_q;
    logic [7:0] txByte_q;
    logic busy_q;
    logic [7:0] shiftIn;
    assign shiftIn = {shift_q[6:0], sdaF};
    logic isFifo;
    assign isFifo = (ptr_q == `TWS_FIFO_ADDR);

    // Bus busy tracking; a repeated start just restarts the frame. [R9]
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_q <= 1'b0;
        end else if (startCond) begin
            busy_q <= 1'b1;
        end else if (stopCond) begin
            busy_q <= 1'b0;
        end
    end

    // Bit engine: sample on SCL rise, MSB first, ninth bit is ack. [R10]
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_q <= TWS_ST_IDLE;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            readDir_q <= 1'b0;
            ackSlot_q <= 1'b0;
            ackOwn_q <= 1'b0;
            ptr_q <= 7'h00;
            wrData <= 8'h00;
            wrStrobe <= 1'b0;
            wrFifo <= 1'b0;
            rdStrobe <= 1'b0;
            rdFifo <= 1'b0;
            txByte_q <= 8'h00;
        end else begin
            wrStrobe <= 1'b0;
            rdStrobe <= 1'b0;
            // The pointer moves only after the strobe, so regAddr names
            // the register that the strobed byte is written to.
            if (wrStrobe && !wrFifo) begin
                ptr_q <= ptr_q + 7'h01; // [R14]
            end
            if (startCond) begin
                phase_q <= TWS_ST_ADDR; // [R9]
                bitCnt_q <= 4'h0;
                ackSlot_q <= 1'b0;
            end else if (stopCond) begin
                phase_q <= TWS_ST_IDLE;
            end else if (phase_q != TWS_ST_IDLE && sclRise) begin
                if (ackSlot_q) begin
                    // Master not-acknowledge ends the read stream. [R12]
                    if (readDir_q && sdaF) begin
                        phase_q <= TWS_ST_IDLE;
                    end
                end else begin
                    shift_q <= shiftIn;
                    bitCnt_q <= bitCnt_q + 4'h1;
                end
            end else if (phase_q != TWS_ST_IDLE && sclFall) begin
                if (ackSlot_q) begin
                    ackSlot_q <= 1'b0;
                    bitCnt_q <= 4'h0;
                    if (readDir_q) begin
                        txByte_q <= rdData;
                        rdFifo <= isFifo;
                        rdStrobe <= 1'b1;
                        if (!isFifo) begin
                            ptr_q <= ptr_q + 7'h01; // [R17]
                        end
                    end
                end else if (bitCnt_q == 4'h8) begin
                    ackSlot_q <= 1'b1;
                    // The device acks its own address and every byte it receives
                    // after it, the read address included, but never a byte it sent.
                    ackOwn_q <= !(phase_q == TWS_ST_DATA && readDir_q); // [R11]
                    case (phase_q)
                        TWS_ST_ADDR: begin
                            // General call and foreign addresses dropped.
                            if (shift_q[7:1] == myAddr) begin // [R2] [R24]
                                readDir_q <= shift_q[0];
                                phase_q <= shift_q[0] ? TWS_ST_DATA
                                                      : TWS_ST_REG;
                            end else begin
                                phase_q <= TWS_ST_IDLE; // [R24]
                            end
                        end
                        TWS_ST_REG: begin
                            ptr_q <= shift_q[6:0]; // [R14] [R16]
                            phase_q <= TWS_ST_DATA;
                        end
                        TWS_ST_DATA: begin
                            if (!readDir_q) begin
                                wrData <= shift_q;
                                wrFifo <= isFifo; // [R15]
                                wrStrobe <= 1'b1;
                            end
                        end
                        default: phase_q <= TWS_ST_IDLE;
                    endcase
                end
            end
        end
    end

    // First read byte is fetched on the address ack fall.
    logic [7:0] txNow;
    assign txNow = (bitCnt_q == 4'h0 && readDir_q) ? txByte_q
                                                   : txByte_q << bitCnt_q;

    // SDA drive, updated only on SCL low so it never moves during SCL
    // high; no SCL output exists, so no stretching or mastering.
    // [R1] [R3] [R4] [R5] [R7] [R19] [R20] [R23]
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sdaOe_q <= 1'b0;
        end else if (startCond || stopCond || phase_q == TWS_ST_IDLE) begin
            sdaOe_q <= 1'b0;
        end else if (!sclF && !sclFall) begin
            if (ackSlot_q) begin
                sdaOe_q <= ackOwn_q; // [R11]
            end else if (readDir_q && phase_q == TWS_ST_DATA) begin
                sdaOe_q <= !txNow[7]; // [R10]
            end else begin
                sdaOe_q <= 1'b0;
            end
        end
    end
    assign link.sdaDevOe = sdaOe_q;

    // Address-phase ack for a read frame is also driven by the device.
    assign regAddr = ptr_q;
    assign busy = busy_q;
endmodule

/* tws_host_end.sv */
// Host end: two-wire master issuing single register writes and reads.
// Assumes the device end answers per the link protocol.
`timescale 1ns/1ps
`include "tws_defs.svh"
module tws_host_end import tws_pkg::*; #(
    parameter int HALF_CYC = `TWS_HALF_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    tws_link_if.host link,
    input wire logic p2pSel,
    input wire logic [6:0] devAddr,
    input wire logic reqValid,
    input wire logic reqRead,
    input wire logic [6:0] reqReg,
    input wire logic [7:0] reqData,
    output logic reqReady,
    output logic [7:0] rspData,
    output logic rspValid,
    output logic rspNack
);
    typedef enum logic [2:0] {
        HS_IDLE, HS_START, HS_BIT, HS_STOP, HS_DONE
    } tws_host_st_t;
    tws_host_st_t st_q;
    logic [15:0] half_q;
    logic [1:0] quarter_q;
    logic [3:0] bitIdx_q;
    logic [1:0] byteIdx_q;
    logic [7:0] sh_q;
    logic rd_q, nack_q, sclLow_q, sdaLow_q;
    logic [7:0] rx_q;
    logic tick;
    assign tick = (half_q == 16'(HALF_CYC - 1));
    assign reqReady = (st_q == HS_IDLE);
    assign link.sclOe = sclLow_q;
    // Point-to-point idle: SDA driven high actively. [R22]
    assign link.sdaHostOe = sdaLow_q || (p2pSel && st_q == HS_IDLE);
    assign link.sdaHostOut = !sdaLow_q;
    assign link.p2pMode = p2pSel;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            half_q <= 16'h0000;
        end else if (st_q == HS_IDLE || tick) begin
            half_q <= 16'h0000;
        end else begin
            half_q <= half_q + 16'h0001;
        end
    end
    // Bytes: 0 address+W, 1 register, 2 data or (read) address+R.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= HS_IDLE;
            sclLow_q <= 1'b0;
            sdaLow_q <= 1'b0;
            quarter_q <= 2'h0;
            bitIdx_q <= 4'h0;
            byteIdx_q <= 2'h0;
            sh_q <= 8'h00;
            rd_q <= 1'b0;
            nack_q <= 1'b0;
            rx_q <= 8'h00;
            rspData <= 8'h00;
            rspValid <= 1'b0;
            rspNack <= 1'b0;
        end else begin
            rspValid <= 1'b0;
            case (st_q)
                HS_IDLE: if (reqValid) begin
                    rd_q <= reqRead;
                    sh_q <= {devAddr, 1'b0};
                    byteIdx_q <= 2'h0;
                    nack_q <= 1'b0;
                    sdaLow_q <= 1'b1;
                    st_q <= HS_START;
                end
                HS_START: if (tick) begin
                    sclLow_q <= 1'b1;
                    bitIdx_q <= 4'h0;
                    quarter_q <= 2'h0;
                    st_q <= HS_BIT;
                end
                HS_BIT: if (tick) begin
                    quarter_q <= quarter_q + 2'h1;
                    case (quarter_q)
                        2'h0: begin
                            // SCL low: set SDA; bit 8 is ack slot.
                            if (bitIdx_q == 4'h8) begin
                                sdaLow_q <= (byteIdx_q == 2'h3 && rd_q)
                                            ? 1'b0 : 1'b0;
                            end else if (byteIdx_q == 2'h3) begin
                                sdaLow_q <= 1'b0;
                            end else begin
                                sdaLow_q <= !sh_q[7];
                            end
                        end
                        2'h1: sclLow_q <= 1'b0;
                        2'h2: begin
                            if (bitIdx_q == 4'h8) begin
                                if (byteIdx_q != 2'h3 && link.sda) begin
                                    nack_q <= 1'b1;
                                end
                            end else begin
                                rx_q <= {rx_q[6:0], link.sda};
                                sh_q <= {sh_q[6:0], 1'b0};
                            end
                        end
                        default: begin
                            sclLow_q <= 1'b1;
                            quarter_q <= 2'h0;
                            if (bitIdx_q != 4'h8) begin
                                bitIdx_q <= bitIdx_q + 4'h1;
                            end else if (nack_q || byteIdx_q == 2'h3
                                || (byteIdx_q == 2'h2 && !rd_q)) begin
                                sdaLow_q <= 1'b1;
                                st_q <= HS_STOP;
                            end else if (byteIdx_q == 2'h1 && rd_q) begin
                                sdaLow_q <= 1'b0;
                                st_q <= HS_DONE;
                            end else begin
                                bitIdx_q <= 4'h0;
                                byteIdx_q <= byteIdx_q + 2'h1;
                                sh_q <= (byteIdx_q == 2'h0)
                                        ? {1'b0, reqReg} : reqData;
                                if (byteIdx_q == 2'h2) begin
                                    byteIdx_q <= 2'h3;
                                end
                            end
                        end
                    endcase
                end
                HS_STOP: if (tick) begin
                    if (sclLow_q) begin
                        sclLow_q <= 1'b0;
                    end else begin
                        sdaLow_q <= 1'b0;
                        rspValid <= 1'b1;
                        rspNack <= nack_q;
                        rspData <= rx_q;
                        st_q <= HS_IDLE;
                    end
                end
                HS_DONE: if (tick) begin
                    // Repeated start, then address with read bit.
                    if (sclLow_q) begin
                        sclLow_q <= 1'b0;
                    end else if (!sdaLow_q) begin
                        sdaLow_q <= 1'b1;
                    end else begin
                        sh_q <= {devAddr, 1'b1};
                        byteIdx_q <= 2'h2;
                        st_q <= HS_START;
                    end
                end
                default: st_q <= HS_IDLE;
            endcase
        end
    end
endmodule

/* tws_link_monitor.sv */
// Checker for the shared wires of the two-wire link.
// Assumes both ends and this checker run on the one core clock.
`timescale 1ns/1ps
module tws_link_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sclOe,
    input wire logic sdaHostOe,
    input wire logic sdaHostOut,
    input wire logic sdaDevOe,
    input wire logic p2pMode,
    input wire logic scl,
    input wire logic sda
);
    logic scl_q;
    logic sda_q;
    logic busy_q;
    logic first_q;
    logic [3:0] bitCnt_q;
    logic startSeen;
    logic stopSeen;
    logic sclFall;

    assign startSeen = scl && scl_q && sda_q && !sda;
    assign stopSeen = scl && scl_q && !sda_q && sda;
    assign sclFall = scl_q && !scl;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_q <= 1'b0;
        end else if (startSeen) begin
            busy_q <= 1'b1;
        end else if (stopSeen) begin
            busy_q <= 1'b0;
        end
    end

    // Counts SCL falls within a byte; first_q marks the address byte.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bitCnt_q <= 4'h0;
            first_q <= 1'b0;
        end else if (startSeen) begin
            // All ones, so the SCL fall after a start wraps to bit 0.
            bitCnt_q <= 4'hF;
            first_q <= 1'b1;
        end else if (sclFall) begin
            bitCnt_q <= (bitCnt_q == 4'h8) ? 4'h0 : bitCnt_q + 4'h1;
            if (bitCnt_q == 4'h8) begin
                first_q <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_dev_rise_low: assert property ($rose(sdaDevOe) |-> !scl)
        else $error("device took SDA while SCL high");
    a_dev_fall_low: assert property ($fell(sdaDevOe) |-> !scl)
        else $error("device let go of SDA while SCL high");
    a_dev_hold_high: assert property (
        (scl && sdaDevOe) |=> (sdaDevOe || !scl))
        else $error("device acknowledge dropped during SCL high");
    a_dev_idle_release: assert property (!busy_q |-> !sdaDevOe)
        else $error("device drives SDA while bus is free");
    a_addr_byte_quiet: assert property (
        (first_q && bitCnt_q < 4'h8) |-> !sdaDevOe)
        else $error("device drives SDA during address byte");
    a_start_clock_soon: assert property (
        startSeen |-> ##[1:200] !scl)
        else $error("no clock pulse after start");
    a_idle_scl_high: assert property (!busy_q |-> (scl && !sclOe))
        else $error("SCL low while bus is free");
    a_p2p_idle_drive: assert property (
        (p2pMode && !busy_q && !startSeen) |-> (sdaHostOe && sdaHostOut))
        else $error("host not driving SDA high on idle link");
    a_data_stable_high: assert property (
        (busy_q && scl && scl_q && bitCnt_q != 4'h0) |-> sda == sda_q)
        else $error("SDA changed during SCL high inside a byte");
endmodule

/* testbench.sv */
// Self-checking bench: host end and device end joined by the link.
// Assumes one 40 MHz core clock for both ends.
`timescale 1ns/1ps
`include "tws_defs.svh"
module testbench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic p2pSel = 1'b0;
    logic [6:0] devAddr = 7'h00;
    logic reqValid = 1'b0;
    logic reqRead = 1'b0;
    logic [6:0] reqReg = 7'h00;
    logic [7:0] reqData = 8'h00;
    logic [1:0] addrPins = 2'b01;
    logic [1:0] addrNv = 2'b00;
    logic addrFromNv = 1'b0;
    logic [7:0] rdData;
    logic reqReady, rspValid, rspNack, wrStrobe, wrFifo;
    logic rdStrobe, rdFifo, busy;
    logic [7:0] rspData, wrData, wrCnt, rdCnt, wrDataSeen;
    logic [6:0] regAddr, wrAddrSeen;
    logic [6:0] goodAddr = 7'h29;
    logic wrFifoSeen, rdFifoSeen, busySeen;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;

    always #12.5 clk = ~clk;

    // Register file stand-in: each address returns a distinct byte.
    assign rdData = {regAddr, 1'b0} ^ 8'hC3;

    tws_link_if link();
    tws_dev_end u_tws_dev_end (.clk(clk), .nrst(nrst), .link(link),
        .addrPins(addrPins), .addrNv(addrNv), .addrFromNv(addrFromNv),
        .regAddr(regAddr), .wrData(wrData), .wrStrobe(wrStrobe),
        .wrFifo(wrFifo), .rdData(rdData), .rdStrobe(rdStrobe),
        .rdFifo(rdFifo), .busy(busy));
    tws_host_end u_tws_host_end (.clk(clk), .nrst(nrst), .link(link),
        .p2pSel(p2pSel), .devAddr(devAddr), .reqValid(reqValid),
        .reqRead(reqRead), .reqReg(reqReg), .reqData(reqData),
        .reqReady(reqReady), .rspData(rspData), .rspValid(rspValid),
        .rspNack(rspNack));
    tws_link_monitor u_tws_link_monitor (.clk(clk), .nrst(nrst),
        .sclOe(link.sclOe), .sdaHostOe(link.sdaHostOe),
        .sdaHostOut(link.sdaHostOut), .sdaDevOe(link.sdaDevOe),
        .p2pMode(link.p2pMode), .scl(link.scl), .sda(link.sda));

    always @(negedge clk) begin
        if (wrStrobe === 1'b1) begin
            wrCnt = wrCnt + 8'h01;
            wrAddrSeen = regAddr;
            wrDataSeen = wrData;
            wrFifoSeen = wrFifo;
        end
        if (rdStrobe === 1'b1) begin
            rdCnt = rdCnt + 8'h01;
            rdFifoSeen = rdFifo;
        end
        if (busy === 1'b1) begin
            busySeen = 1'b1;
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            fails++;
            summarize();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic xfer(input logic [6:0] a, input logic rd,
        input logic [6:0] r, input logic [7:0] d);
        int n;
        n = 0;
        wrCnt = 8'h00;
        rdCnt = 8'h00;
        busySeen = 1'b0;
        @(posedge clk);
        #2;
        devAddr = a;
        reqRead = rd;
        reqReg = r;
        reqData = d;
        reqValid = 1'b1;
        while (reqReady !== 1'b1 && n < 100) begin
            @(posedge clk);
            #2;
            n++;
        end
        @(posedge clk);
        #2;
        reqValid = 1'b0;
        n = 0;
        while (rspValid !== 1'b1 && n < 8000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check({7'h00, rspValid}, 8'h01);
        // The device sees the stop through its filter; keep the bus free
        // long enough before the next start.
        repeat (16) @(posedge clk);
        #2;
    endtask

    task automatic t_write(input logic [6:0] r, input logic [7:0] d,
        input logic fifo);
        xfer(goodAddr, 1'b0, r, d);
        check({7'h00, rspNack}, 8'h00);
        check(wrCnt, 8'h01);
        check({1'b0, wrAddrSeen}, {1'b0, r});
        check(wrDataSeen, d);
        check({7'h00, wrFifoSeen}, {7'h00, fifo});
        check({7'h00, busySeen}, 8'h01);
        check({7'h00, busy}, 8'h00);
        if (fifo) begin
            check({1'b0, regAddr}, {1'b0, r});
        end
        $display("write test done at %0t", $time);
    endtask

    task automatic t_read(input logic [6:0] r, input logic fifo);
        xfer(goodAddr, 1'b1, r, 8'h00);
        check({7'h00, rspNack}, 8'h00);
        check(wrCnt, 8'h00);
        check(rdCnt, 8'h01);
        check(rspData, {r, 1'b0} ^ 8'hC3);
        check({7'h00, rdFifoSeen}, {7'h00, fifo});
        check({1'b0, regAddr}, {1'b0, fifo ? r : r + 7'h01});
        $display("read test done at %0t", $time);
    endtask

    task automatic t_reject(input logic [6:0] a);
        xfer(a, 1'b0, 7'h12, 8'h5A);
        check({7'h00, rspNack}, 8'h01);
        check(wrCnt, 8'h00);
        $display("reject test done at %0t", $time);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        #2;
        nrst = 1'b1;
        t_write(7'h12, 8'hA5, 1'b0);
        t_write(`TWS_FIFO_ADDR, 8'h3C, 1'b1);
        t_read(7'h21, 1'b0);
        t_read(`TWS_FIFO_ADDR, 1'b1);
        t_reject(7'h4A);
        t_reject(7'h00);
        t_reject(7'h2B);
        addrFromNv = 1'b1;
        addrNv = 2'b10;
        goodAddr = 7'h2A;
        t_reject(7'h29);
        t_write(7'h33, 8'h0F, 1'b0);
        // Pin mode on the point-to-point link forces the upper bit to 0.
        p2pSel = 1'b1;
        addrFromNv = 1'b0;
        addrPins = 2'b11;
        goodAddr = 7'h29;
        t_reject(7'h2B);
        t_write(7'h40, 8'h81, 1'b0);
        t_read(7'h7E, 1'b0);
        summarize();
    end
endmodule
